// [bench/scp_host.sv]
`default_nettype none
// host side: sends frames, samples sdo at each rising sclk
module scp_host (
  output logic      sclk,
  output logic      sdi,
  output logic      latch,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [47:0] rx = 48'h0;
  initial {sclk, sdi, latch} = 3'h0;
  // sclk rests low outside a burst of exactly n clocks
  task automatic frame(logic [47:0] w, int n);
    latch = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = w[i];
      #15 sclk = 1'b1;
      rx = {rx[46:0], sdo};
      #15 sclk = 1'b0;
    end
    sdi = ~sdi; // no stale level once the frame is over
    #15 latch = 1'b1;
    #300; // clock stands still until the commit lands
  endtask : frame
endmodule : scp_host
`default_nettype wire

// [bench/scp_top_props.sv]
`default_nettype none
module scp_top_props (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        latch,
  input wire logic        chain_enable,
  input wire logic        frame_busy,
  input wire logic        commit_pulse,
  input wire logic        soft_reset_pulse,
  input wire logic [15:0] control,
  input wire logic [15:0] configuration,
  input wire logic [15:0] output_code
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // strobe seen low then high in the system domain
  sequence s_latch_rise;
    !latch ##1 latch;
  endsequence
  a_commit_follows:
    assert property (s_latch_rise |-> ##[2:5] commit_pulse)
    else $error("no commit after latch");
  a_one_commit: assert property (commit_pulse |=> !commit_pulse)
    else $error("commit pulse too long");
  a_commit_held: assert property (commit_pulse |-> latch)
    else $error("commit while latch low");
  a_reg_on_commit:
    assert property ($changed(output_code) || $changed(control)
      |-> commit_pulse) else $error("register moved alone");
  a_busy_drops: assert property (latch [*4] |-> !frame_busy)
    else $error("busy held under latch");
  a_cfg_reserved: assert property (configuration[15:11] == 5'h00)
    else $error("reserved bits stored");
  a_chain_on_commit:
    assert property ($changed(chain_enable) |-> commit_pulse)
    else $error("chain enable moved alone");
  a_soft_clears:
    assert property (soft_reset_pulse |-> ##[0:1] control == 16'h0000
      && output_code == 16'h0000) else $error("soft reset kept data");
endmodule : scp_top_props
`default_nettype wire

// [bench/tb_serial_chain_command_port.sv]
`default_nettype none
module tb_serial_chain_command_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  flt = 5'h00;
  logic        sclk, sdi, latch, sdo, chain_enable;
  logic        frame_busy, commit_pulse, soft_reset_pulse;
  logic [15:0] control, configuration, output_code;
  logic [15:0] gain_trim, offset_trim;
  logic [15:0] mdl [5] = '{default: 16'h0000};
  logic [7:0]  wa [5] = '{8'h01, 8'h55, 8'h57, 8'h58, 8'h59};
  logic [5:0]  ra [5] = '{6'h01, 6'h02, 6'h0b, 6'h13, 6'h17};
  logic [7:0]  nc [4] = '{8'h00, 8'h95, 8'h02, 8'h33};
  int          mismatches = 0;
  int          check_count = 0;
  int          seed = 98611;
  int          busy_n = 0;
  int          srst_n = 0;
  // 24 sclk periods of 30 ns span 36 clk periods of 20 ns
  localparam int BUSY_24 = scp_pkg::FRAME_W * 3 / 2;
  wire logic [79:0] regs = {offset_trim, gain_trim, configuration,
                            control, output_code};
  always #10 clk = ~clk;
  // busy level and soft reset strobes, taken where they are settled
  always @(negedge clk) begin
    if (frame_busy === 1'b1) busy_n++;
    if (soft_reset_pulse === 1'b1) srst_n++;
  end
  scp_host host (.sclk, .sdi, .latch, .sdo);
  scp_top uut (.clk, .rstn, .sclk, .sdi, .latch,
    .frame_check_fault(flt[4]), .timeout_fault(flt[3]),
    .current_loop_fault(flt[2]), .slewing_active(flt[1]),
    .overtemp_fault(flt[0]), .sdo, .chain_enable, .frame_busy,
    .commit_pulse, .soft_reset_pulse, .control, .configuration,
    .output_code, .gain_trim, .offset_trim);
  task automatic cmp(string what, logic [23:0] exp, logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // what a write leaves: upper configuration bits drop
  function automatic logic [15:0] kept(int i, logic [15:0] d);
    return (i == 2) ? (d & scp_pkg::CFG_KEEP_MASK) : d;
  endfunction : kept
  // request frame, then a no-op frame whose far half is fw
  task automatic rd(logic [5:0] s, int n, logic [23:0] fw,
                    output logic [47:0] q);
    host.frame({fw, scp_pkg::CMD_READ, 10'h000, s}, n);
    host.frame({fw, 24'h000000}, n);
    q = host.rx;
  endtask : rd
  // every register at its port and by readback; ch: chaining on
  task automatic check_all(int n, logic [23:0] fw, logic ch);
    logic [47:0] q;
    for (int i = 0; i < 5; i++) begin
      cmp("register", {8'h00, mdl[i]}, {8'h00, regs[i*16 +: 16]});
      rd(i < 2 ? {4'($random(seed)), ra[i][1:0]} : ra[i], n, fw, q);
      cmp("readback", {8'h00, mdl[i]}, q[n-1 -: 24]);
      if (n == 48) cmp("relay", ch ? fw : 24'h0, q[23:0]);
    end
  endtask : check_all
  // main sequence: corners first, then random data
  initial begin
    logic [15:0] d;
    logic [23:0] fw;
    logic [47:0] q;
    int          b;
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    check_all(24, 24'h0, 1'b0);
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 5; i++) begin
        d = (r == 0) ? 16'hffff : 16'($random(seed));
        if (i == 1) d[3] = 1'b0;
        host.frame({24'h0, wa[i], d}, 24);
        mdl[i] = kept(i, d);
      end
      @(posedge clk);
      #1 flt = 5'($random(seed));
      rd({4'($random(seed)), 2'b00}, 24, 24'h0, q);
      cmp("status", {19'h0, flt}, q[23:0]);
      check_all(24, 24'h0, 1'b0);
    end
    foreach (nc[k])
      host.frame({24'h0, nc[k], 16'($random(seed))}, 24);
    host.frame({24'h0, scp_pkg::CMD_WR_RST, 16'hfffe}, 24);
    cmp("soft resets", 24'd0, 24'(srst_n));
    check_all(24, 24'h0, 1'b0);
    host.frame({24'h0, scp_pkg::CMD_WR_RST, 16'h0001}, 24);
    cmp("soft resets", 24'd1, 24'(srst_n));
    mdl = '{default: 16'h0000};
    check_all(24, 24'h0, 1'b0);
    b = busy_n;
    host.frame({24'h0, scp_pkg::CMD_WR_CTRL, 16'h0008}, 24);
    cmp("busy cycles", 24'(BUSY_24), 24'(busy_n - b));
    mdl[1] = 16'h0008;
    d = 16'($random(seed));
    host.frame({24'h0, scp_pkg::CMD_WDOG, d}, 24);
    fw = 24'($random(seed));
    b = busy_n;
    host.frame({fw, scp_pkg::CMD_WR_CODE, ~d}, 48);
    cmp("busy cycles", 24'(2 * BUSY_24), 24'(busy_n - b));
    mdl[0] = ~d;
    cmp("relay", {scp_pkg::CMD_WDOG, d}, host.rx[47:24]);
    cmp("relay", fw, host.rx[23:0]);
    check_all(48, 24'($random(seed)), 1'b1);
    host.frame({24'h0, scp_pkg::CMD_WR_CTRL, 16'h0000}, 24);
    mdl[1] = 16'h0000;
    check_all(48, 24'($random(seed)), 1'b0);
    report_and_stop();
  end
endmodule : tb_serial_chain_command_port
bind scp_top scp_top_props u_props (.clk, .rstn, .latch, .chain_enable,
  .frame_busy, .commit_pulse, .soft_reset_pulse, .control,
  .configuration, .output_code);
`default_nettype wire

// [hdl/scp_link.sv]
`default_nettype none
// link side, clocked by the serial clock of the host
module scp_link #(
  parameter int FRAME_W = scp_pkg::FRAME_W
) (
  input  wire logic               sclk,
  input  wire logic               rstn,
  input  wire logic               sdi,
  input  wire logic               latch,
  input  wire logic               chain_en,
  input  wire logic               rd_armed,
  input  wire logic [FRAME_W-1:0] rb_word,
  output logic      [FRAME_W-1:0] shift_q,
  output logic                    frame_busy,
  output logic                    sdo
);
  localparam int CW = scp_pkg::CNT_W;
  localparam logic [CW-1:0] LAST = CW'(FRAME_W - 2);

  logic [FRAME_W-1:0] sr_r;
  logic [CW-1:0]      cnt_r;
  logic               lead_r;
  logic               sdo_r;
  logic               busy_r;
  logic               chn_s1_r;
  logic               chn_s2_r;
  logic               sdo_nxt;
  logic               lead_bit;
  wire                frame_arst = latch | ~rstn;

  // shift in msb first on rising edges, cleared only by reset
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) sr_r <= scp_pkg::SR_RST;
    else       sr_r <= {sr_r[FRAME_W-2:0], sdi};
  end

  // first rising edge after latch opens the write cycle
  always_ff @(posedge sclk or posedge frame_arst) begin
    if (frame_arst) busy_r <= 1'b0;
    else            busy_r <= 1'b1;
  end

  // chain enable crosses on the falling edge it is used on
  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) begin
      chn_s1_r <= 1'b0;
      chn_s2_r <= 1'b0;
    end else begin
      chn_s1_r <= chain_en;
      chn_s2_r <= chn_s1_r;
    end
  end

  // falling edge count since latch; latch high holds it at zero
  always_ff @(negedge sclk or posedge frame_arst) begin
    if (frame_arst) begin
      cnt_r  <= '0;
      lead_r <= 1'b1;
    end else begin
      lead_r <= 1'b0;
      if (cnt_r <= LAST) cnt_r <= cnt_r + 1'b1;
    end
  end

  // own readback word first, then the upstream bits 24 clocks late
  assign sdo_nxt = (rd_armed && cnt_r <= LAST) ?
                   rb_word[LAST - cnt_r] :
                   (chn_s2_r ? sr_r[FRAME_W-1] : 1'b0);

  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) sdo_r <= 1'b0;
    else       sdo_r <= sdo_nxt;
  end

  // msb must stand before the first clock, so it bypasses sdo_r
  assign lead_bit   = rd_armed ? rb_word[FRAME_W-1] :
                      (chn_s2_r ? sr_r[FRAME_W-1] : 1'b0);
  assign sdo        = lead_r ? lead_bit : sdo_r;
  assign shift_q    = sr_r;
  assign frame_busy = busy_r;
endmodule : scp_link
`default_nettype wire

// [hdl/scp_pkg.sv]
`default_nettype none
package scp_pkg;
  // frame layout
  localparam int FRAME_W = 24;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 16;
  localparam int CNT_W   = 5;
  localparam int RSEL_W  = 6;
  localparam int STAT_W  = 5;

  // address byte codes
  localparam logic [7:0] CMD_NOP     = 8'h00;
  localparam logic [7:0] CMD_WR_CODE = 8'h01;
  localparam logic [7:0] CMD_READ    = 8'h02;
  localparam logic [7:0] CMD_WR_CTRL = 8'h55;
  localparam logic [7:0] CMD_WR_RST  = 8'h56;
  localparam logic [7:0] CMD_WR_CFG  = 8'h57;
  localparam logic [7:0] CMD_WR_GAIN = 8'h58;
  localparam logic [7:0] CMD_WR_OFFS = 8'h59;
  localparam logic [7:0] CMD_WDOG    = 8'h95;

  // read selects: three use only the low two bits
  localparam logic [1:0] RD_STATUS = 2'h0;
  localparam logic [1:0] RD_CODE   = 2'h1;
  localparam logic [1:0] RD_CTRL   = 2'h2;
  localparam logic [5:0] RD_CFG    = 6'h0b;
  localparam logic [5:0] RD_GAIN   = 6'h13;
  localparam logic [5:0] RD_OFFS   = 6'h17;

  // field positions and values
  localparam int          CTRL_CHAIN_BIT = 3;
  localparam int          SRST_BIT       = 0;
  localparam logic [15:0] CFG_KEEP_MASK  = 16'h07ff;
  localparam logic [15:0] REG_RST        = 16'h0000;
  localparam logic [23:0] SR_RST         = 24'h000000;
  localparam logic [7:0]  RB_HEAD        = 8'h00;
  localparam logic [10:0] STAT_PAD       = 11'h000;

  typedef enum logic {RD_IDLE, RD_ARMED} scp_rd_type;
endpackage : scp_pkg
`default_nettype wire

// [hdl/scp_top.sv]
`default_nettype none
module scp_top #(
  parameter int FRAME_W = scp_pkg::FRAME_W
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        sclk,
  input  wire logic        sdi,
  input  wire logic        latch,
  input  wire logic        frame_check_fault,
  input  wire logic        timeout_fault,
  input  wire logic        current_loop_fault,
  input  wire logic        slewing_active,
  input  wire logic        overtemp_fault,
  output logic             sdo,
  output logic             chain_enable,
  output logic             frame_busy,
  output logic             commit_pulse,
  output logic             soft_reset_pulse,
  output logic [15:0]      control,
  output logic [15:0]      configuration,
  output logic [15:0]      output_code,
  output logic [15:0]      gain_trim,
  output logic [15:0]      offset_trim
);
  localparam int DW = scp_pkg::DATA_W;
  localparam int AW = scp_pkg::ADDR_W;

  logic [FRAME_W-1:0] link_word;
  logic               link_busy;
  logic               lat_s1_r;
  logic               lat_s2_r;
  logic               lat_d_r;
  logic               busy_s1_r;
  logic               busy_s2_r;
  logic               commit_r;
  logic               srst_r;
  logic [DW-1:0]      control_r;
  logic [DW-1:0]      config_r;
  logic [DW-1:0]      code_r;
  logic [DW-1:0]      gain_r;
  logic [DW-1:0]      offs_r;
  logic [FRAME_W-1:0] rb_r;
  logic [FRAME_W-1:0] rb_nxt;
  scp_pkg::scp_rd_type rd_st_r;
  scp_pkg::scp_rd_type rd_st_nxt;

  // pick the register named by a read request
  function automatic logic [DW-1:0] rd_pick(
    input logic [scp_pkg::RSEL_W-1:0] sel,
    input logic [DW-1:0]              stat,
    input logic [DW-1:0]              code,
    input logic [DW-1:0]              ctrl,
    input logic [DW-1:0]              cfg,
    input logic [DW-1:0]              gain,
    input logic [DW-1:0]              offs
  );
    logic [DW-1:0] val;
    val = scp_pkg::REG_RST;
    if (sel == scp_pkg::RD_CFG)            val = cfg;
    else if (sel == scp_pkg::RD_GAIN)      val = gain;
    else if (sel == scp_pkg::RD_OFFS)      val = offs;
    else if (sel[1:0] == scp_pkg::RD_STATUS) val = stat;
    else if (sel[1:0] == scp_pkg::RD_CODE) val = code;
    else if (sel[1:0] == scp_pkg::RD_CTRL) val = ctrl;
    return val;
  endfunction : rd_pick

  // link side; readback word and read flag only change while latch
  // is high, when the link holds off reading them
  scp_link #(
    .FRAME_W    (FRAME_W)
  ) u_link (
    .sclk       (sclk),
    .rstn       (rstn),
    .sdi        (sdi),
    .latch      (latch),
    .chain_en   (control_r[scp_pkg::CTRL_CHAIN_BIT]),
    .rd_armed   (rd_st_r == scp_pkg::RD_ARMED),
    .rb_word    (rb_r),
    .shift_q    (link_word),
    .frame_busy (link_busy),
    .sdo        (sdo)
  );

  // latch and busy pins pass two flops before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lat_s1_r  <= 1'b0;
      lat_s2_r  <= 1'b0;
      lat_d_r   <= 1'b0;
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
    end else begin
      lat_s1_r  <= latch;
      lat_s2_r  <= lat_s1_r;
      lat_d_r   <= lat_s2_r;
      busy_s1_r <= link_busy;
      busy_s2_r <= busy_s1_r;
    end
  end

  // frame word is quiet after the last clock, so sampling it a few
  // cycles after latch rises is safe; a clock that keeps running
  // past the latch edge would corrupt it
  wire            lat_rise = lat_s2_r & ~lat_d_r;
  wire [AW-1:0]   cmd      = link_word[FRAME_W-1:DW];
  wire [DW-1:0]   dat      = link_word[DW-1:0];
  wire            wr_code  = lat_rise && cmd == scp_pkg::CMD_WR_CODE;
  wire            wr_ctrl  = lat_rise && cmd == scp_pkg::CMD_WR_CTRL;
  wire            wr_cfg   = lat_rise && cmd == scp_pkg::CMD_WR_CFG;
  wire            wr_gain  = lat_rise && cmd == scp_pkg::CMD_WR_GAIN;
  wire            wr_offs  = lat_rise && cmd == scp_pkg::CMD_WR_OFFS;
  wire            rd_req   = lat_rise && cmd == scp_pkg::CMD_READ;
  wire            do_srst  = lat_rise && cmd == scp_pkg::CMD_WR_RST &&
                             dat[scp_pkg::SRST_BIT];
  wire [DW-1:0]   stat_w   = {scp_pkg::STAT_PAD, frame_check_fault,
                              timeout_fault, current_loop_fault,
                              slewing_active, overtemp_fault};

  // a read arms the next frame; any other commit disarms it
  assign rd_st_nxt = !lat_rise ? rd_st_r :
                     (rd_req ? scp_pkg::RD_ARMED : scp_pkg::RD_IDLE);
  assign rb_nxt = rd_req ?
                  {scp_pkg::RB_HEAD,
                   rd_pick(dat[scp_pkg::RSEL_W-1:0], stat_w, code_r,
                           control_r, config_r, gain_r, offs_r)} : rb_r;

  // read path state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_st_r <= scp_pkg::RD_IDLE;
      rb_r    <= scp_pkg::SR_RST;
    end else begin
      rd_st_r <= rd_st_nxt;
      rb_r    <= rb_nxt;
    end
  end

  // addressed registers; no-op, read and watchdog words fall through
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control_r <= scp_pkg::REG_RST;
      config_r  <= scp_pkg::REG_RST;
      code_r    <= scp_pkg::REG_RST;
      gain_r    <= scp_pkg::REG_RST;
      offs_r    <= scp_pkg::REG_RST;
    end else if (do_srst) begin
      control_r <= scp_pkg::REG_RST;
      config_r  <= scp_pkg::REG_RST;
      code_r    <= scp_pkg::REG_RST;
      gain_r    <= scp_pkg::REG_RST;
      offs_r    <= scp_pkg::REG_RST;
    end else begin
      if (wr_ctrl) control_r <= dat;
      if (wr_cfg)  config_r  <= dat & scp_pkg::CFG_KEEP_MASK;
      if (wr_code) code_r    <= dat;
      if (wr_gain) gain_r    <= dat;
      if (wr_offs) offs_r    <= dat;
    end
  end

  // event strobes for the rest of the chip
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      commit_r <= 1'b0;
      srst_r   <= 1'b0;
    end else begin
      commit_r <= lat_rise;
      srst_r   <= do_srst;
    end
  end

  assign chain_enable     = control_r[scp_pkg::CTRL_CHAIN_BIT];
  assign frame_busy       = busy_s2_r;
  assign commit_pulse     = commit_r;
  assign soft_reset_pulse = srst_r;
  assign control          = control_r;
  assign configuration    = config_r;
  assign output_code      = code_r;
  assign gain_trim        = gain_r;
  assign offset_trim      = offs_r;
endmodule : scp_top
`default_nettype wire
